// file: rtl/bcp_defs.vh
// Constants for the buck switch protection control block.
// Assumes a 200 MHz system clock; all cycle counts are derived from it.
`ifndef BCP_DEFS_VH
`define BCP_DEFS_VH

// Counts are sized to their users, 5 ns a cycle
// Bootstrap refresh after 3 ms of high-side off time
`define BCP_BOOT_CYC 20'h927C0
// Soft-start capacitor discharge, 530 us least time
`define BCP_DISCH_CYC 20'h19E10
// Switch-node pull-down timeout after a max-on turn-off, 1 us
`define BCP_TMO_CYC 16'h00C8
// Current-sense blanking, 120 ns
`define BCP_BLANK_CYC 16'h0018
// Minimum off interval, 200 ns; a plain default
`define BCP_MIN_OFF_CYC 16'h0028
// Maximum on interval, 4 us; a plain default
`define BCP_MAX_ON_CYC 16'h0320
// Skipped-pulse count ceiling
`define BCP_SKIP_MAX 3'h7
// Number of synchronised comparator inputs
`define BCP_NSYNC 13

`endif

// file: rtl/bcp_sync.v
// Two-flop synchroniser bank for comparator and pin inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none

module bcp_sync #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      // First flop feeds only the second
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= din[i];
          stable <= meta;
        end
      end
      assign dout[i] = stable;
    end
  endgenerate

endmodule // bcp_sync

`default_nettype wire

// file: rtl/bcp_ctrl.v
// Digital control of a step-down regulator's high-side switch.
// Assumes analog comparators and oscillator outside, asynchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "bcp_defs.vh"

module bcp_ctrl #(
  parameter [19:0] BOOT_CYC = `BCP_BOOT_CYC,
  parameter [19:0] DISCH_CYC = `BCP_DISCH_CYC,
  parameter [15:0] MIN_OFF_CYC = `BCP_MIN_OFF_CYC,
  parameter [15:0] MAX_ON_CYC = `BCP_MAX_ON_CYC
) (
  input wire clk_sys,
  input wire arst_n,
  input wire osc_period,
  input wire ea_at_bottom,
  input wire pwm_end,
  input wire ilim_nominal_trip,
  input wire ilim_fold_trip,
  input wire iskip_reached,
  input wire ineg_limit,
  input wire feedback_below_fold,
  input wire ramp_done,
  input wire temp_hot,
  input wire temp_release,
  input wire enable_on,
  input wire supply_ok,
  output reg high_side_switch,
  output reg low_side_pulldown,
  output reg ramp_discharge,
  output reg soft_start_active,
  output reg thermal_shutdown,
  output reg standby,
  output reg [2:0] skip_count
);

  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_DISCH = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;
  localparam [1:0] ST_HOT = 2'h3;

  localparam [1:0] PH_IDLE = 2'h0;
  localparam [1:0] PH_ON = 2'h1;
  localparam [1:0] PH_OFFMIN = 2'h2;
  localparam [1:0] PH_LDO = 2'h3;

  localparam [15:0] BLANK_CYC = `BCP_BLANK_CYC;
  localparam [15:0] TMO_CYC = `BCP_TMO_CYC;
  localparam [2:0] SKIP_MAX = `BCP_SKIP_MAX;

  wire [`BCP_NSYNC-1:0] s_in;
  wire s_tick_lvl;
  wire s_bottom;
  wire s_pwm_end;
  wire s_ilim_nom;
  wire s_ilim_fold;
  wire s_iskip;
  wire s_ineg;
  wire s_fb_low;
  wire s_ramp_done;
  wire s_hot;
  wire s_release;
  wire s_en;
  wire s_supply;

  bcp_sync #(
    .W(`BCP_NSYNC)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .din({osc_period, ea_at_bottom, pwm_end, ilim_nominal_trip,
          ilim_fold_trip, iskip_reached, ineg_limit, feedback_below_fold,
          ramp_done, temp_hot, temp_release, enable_on, supply_ok}),
    .dout(s_in)
  );

  assign s_tick_lvl = s_in[12];
  assign s_bottom = s_in[11];
  assign s_pwm_end = s_in[10];
  assign s_ilim_nom = s_in[9];
  assign s_ilim_fold = s_in[8];
  assign s_iskip = s_in[7];
  assign s_ineg = s_in[6];
  assign s_fb_low = s_in[5];
  assign s_ramp_done = s_in[4];
  assign s_hot = s_in[3];
  assign s_release = s_in[2];
  assign s_en = s_in[1];
  assign s_supply = s_in[0];

  reg [1:0] state;
  reg [1:0] phase;
  reg [19:0] cnt;
  reg [15:0] ph_cnt;
  reg [19:0] off_cnt;
  reg [2:0] skip_left;
  reg light;
  reg tick_d;

  reg [1:0] next_state;
  reg [1:0] next_phase;
  reg [19:0] next_cnt;
  reg [15:0] next_ph_cnt;
  reg [19:0] next_off_cnt;
  reg [2:0] next_skip_count;
  reg [2:0] next_skip_left;
  reg next_light;
  reg next_ss;

  wire tick;
  wire run_ok;
  wire fold_en;
  wire oc_trip;
  wire boot_pd;

  assign tick = s_tick_lvl & ~tick_d;
  assign run_ok = s_en & s_supply;
  // Fold only outside soft-start, which runs at the nominal limit
  assign fold_en = s_fb_low & ~soft_start_active;
  // The folded trip also needs skip current, so the limit floors there
  assign oc_trip = fold_en ? (s_ilim_fold & s_iskip) : s_ilim_nom;
  assign boot_pd = (next_off_cnt == BOOT_CYC);

  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_ss = soft_start_active;
    next_phase = phase;
    next_ph_cnt = ph_cnt;
    next_off_cnt = off_cnt;
    next_skip_count = skip_count;
    next_skip_left = skip_left;
    next_light = light;
    case (state)
      ST_OFF: begin
        if (run_ok) begin
          next_state = ST_DISCH;
          next_cnt = 20'h0;
        end
      end
      ST_DISCH: begin
        if (s_hot) begin
          next_state = ST_HOT;
        end else if (cnt == DISCH_CYC - 20'h1) begin
          next_state = ST_RUN;
          next_ss = 1'b1;
        end else begin
          next_cnt = cnt + 20'h1;
        end
      end
      ST_RUN: begin
        if (s_hot) begin
          next_state = ST_HOT;
        end else if (s_ramp_done) begin
          next_ss = 1'b0;
        end
      end
      default: begin
        if (s_release && !s_hot) begin
          next_state = ST_DISCH;
          next_cnt = 20'h0;
        end
      end
    endcase
    if (!run_ok) begin
      next_state = ST_OFF;
    end
    if (next_state != ST_RUN) begin
      next_ss = 1'b0;
    end
    if (state != ST_RUN || next_state != ST_RUN) begin
      next_phase = PH_IDLE;
      next_ph_cnt = 16'h0;
      next_off_cnt = 20'h0;
      next_skip_count = 3'h0;
      next_skip_left = 3'h0;
      next_light = 1'b0;
    end else begin
      case (phase)
        PH_IDLE: begin
          if (tick) begin
            if (skip_left != 3'h0) begin
              next_skip_left = skip_left - 3'h1;
            end else if (s_bottom) begin
              next_light = 1'b1;
            end else begin
              next_phase = PH_ON;
              next_ph_cnt = 16'h0;
            end
          end
        end
        PH_ON: begin
          next_ph_cnt = ph_cnt + 16'h1;
          if (ph_cnt < BLANK_CYC - 16'h1) begin
            next_phase = PH_ON;
          end else if (ph_cnt == BLANK_CYC - 16'h1) begin
            if (oc_trip) begin
              next_phase = PH_OFFMIN;
              next_ph_cnt = 16'h0;
              next_light = 1'b0;
              if (skip_count != SKIP_MAX) begin
                next_skip_count = skip_count + 3'h1;
              end
              next_skip_left = next_skip_count;
            end else if (skip_count != 3'h0) begin
              next_skip_count = skip_count - 3'h1;
            end
          end else if (oc_trip) begin
            next_phase = PH_OFFMIN;
            next_ph_cnt = 16'h0;
            next_light = 1'b0;
          end else if (light ? s_iskip : s_pwm_end) begin
            next_phase = PH_OFFMIN;
            next_ph_cnt = 16'h0;
            next_light = 1'b0;
          end else if (ph_cnt >= MAX_ON_CYC - 16'h1) begin
            next_phase = PH_LDO;
            next_ph_cnt = 16'h0;
            next_light = 1'b0;
          end
        end
        PH_OFFMIN: begin
          // Ticks landing here are lost; that period stays off
          if (ph_cnt >= MIN_OFF_CYC - 16'h1) begin
            next_phase = PH_IDLE;
            next_ph_cnt = 16'h0;
          end else begin
            next_ph_cnt = ph_cnt + 16'h1;
          end
        end
        default: begin
          if (s_ineg || ph_cnt >= TMO_CYC - 16'h1) begin
            next_phase = PH_OFFMIN;
            next_ph_cnt = 16'h0;
          end else begin
            next_ph_cnt = ph_cnt + 16'h1;
          end
        end
      endcase
      if (next_phase == PH_ON) begin
        next_off_cnt = 20'h0;
      end else if (off_cnt != BOOT_CYC) begin
        next_off_cnt = off_cnt + 20'h1;
      end
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_OFF;
      phase <= PH_IDLE;
      cnt <= 20'h0;
      ph_cnt <= 16'h0;
      off_cnt <= 20'h0;
      skip_left <= 3'h0;
      light <= 1'b0;
      tick_d <= 1'b0;
      high_side_switch <= 1'b0;
      low_side_pulldown <= 1'b0;
      ramp_discharge <= 1'b0;
      soft_start_active <= 1'b0;
      thermal_shutdown <= 1'b0;
      standby <= 1'b1;
      skip_count <= 3'h0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cnt <= next_cnt;
      ph_cnt <= next_ph_cnt;
      off_cnt <= next_off_cnt;
      skip_left <= next_skip_left;
      light <= next_light;
      tick_d <= s_tick_lvl;
      high_side_switch <= (next_phase == PH_ON);
      // Pull-down never overlaps conduction
      low_side_pulldown <= (next_phase == PH_LDO) ||
                           (boot_pd && next_phase != PH_ON);
      ramp_discharge <= (next_state == ST_DISCH);
      soft_start_active <= next_ss;
      thermal_shutdown <= (next_state == ST_HOT);
      standby <= (next_state == ST_OFF);
      skip_count <= next_skip_count;
    end
  end

endmodule // bcp_ctrl

`default_nettype wire

// file: verif/bcp_ctrl_sva.sv
// Checker on the switch control outputs.
// Assumes a bind to bcp_ctrl with its count parameters.
`timescale 1ns/10ps
`default_nettype none
module bcp_ctrl_sva #(
  parameter [19:0] DISCH_CYC = 20'h1,
  parameter [15:0] MIN_OFF_CYC = 16'h1,
  parameter [15:0] MAX_ON_CYC = 16'h1
) (
  input wire clk_sys,
  input wire arst_n,
  input wire enable_on,
  input wire high_side_switch,
  input wire low_side_pulldown,
  input wire ramp_discharge,
  input wire thermal_shutdown,
  input wire standby,
  input wire [2:0] skip_count
);
  reg [19:0] on_n;
  reg [19:0] off_n;
  reg [19:0] dis_n;
  wire run = !standby && !thermal_shutdown;
  // Off count starts high so the first turn-on is not flagged
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      on_n <= 20'h0;
      off_n <= 20'h80000;
      dis_n <= 20'h0;
    end else begin
      on_n <= high_side_switch ? on_n + 20'h1 : 20'h0;
      off_n <= high_side_switch ? 20'h0 : off_n + 20'h1;
      dis_n <= ramp_discharge ? dis_n + 20'h1 : 20'h0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence en_low_s;
    !enable_on [*5];
  endsequence
  disch_len_a: assert property (
    $fell(ramp_discharge) && run |-> dis_n >= DISCH_CYC)
    else $error("discharge too short");
  idle_off_a: assert property (
    standby || thermal_shutdown || ramp_discharge |-> !high_side_switch)
    else $error("switch on while idle");
  min_off_a: assert property (
    $rose(high_side_switch) |-> off_n >= MIN_OFF_CYC)
    else $error("off interval too short");
  max_on_a: assert property (
    high_side_switch |-> on_n < MAX_ON_CYC)
    else $error("on interval too long");
  pdn_after_a: assert property (
    $fell(high_side_switch) && on_n == MAX_ON_CYC |-> ##[0:1]
    low_side_pulldown)
    else $error("no pull-down after cap");
  blank_a: assert property (
    $fell(high_side_switch) && run |-> on_n >= 20'h18)
    else $error("pulse ended inside blanking");
  skip_step_a: assert property (
    $changed(skip_count) && run |-> skip_count == $past(skip_count) + 3'h1
    || skip_count == $past(skip_count) - 3'h1)
    else $error("skip count jumped");
  stby_a: assert property (
    en_low_s |-> standby)
    else $error("no standby");
endmodule // bcp_ctrl_sva
`default_nettype wire

// file: verif/bcp_plant.sv
// Far side: oscillator, current ramp and comparators.
// Assumes current rises only while the high side conducts.
`timescale 1ns/10ps
`default_nettype none
module bcp_plant (
  input wire clk_sys,
  input wire high_side_switch,
  input wire low_side_pulldown,
  input wire short_ckt,
  input wire [7:0] pwm_len,
  output wire osc_period,
  output wire pwm_end,
  output wire ilim_nominal_trip,
  output wire ilim_fold_trip,
  output wire iskip_reached,
  output wire ineg_limit
);
  logic [7:0] tick = 8'h0;
  logic [7:0] il = 8'h0;
  logic [7:0] pd = 8'h0;
  // Current restarts each pulse, a simple discontinuous load
  always @(posedge clk_sys) begin
    tick <= tick + 8'h1;
    il <= high_side_switch ? il + {7'h0, il != 8'hFF} : 8'h0;
    pd <= low_side_pulldown ? pd + {7'h0, pd != 8'hFF} : 8'h0;
  end
  assign osc_period = tick < 8'h4;
  assign pwm_end = il >= pwm_len;
  assign iskip_reached = il >= 8'h1C;
  assign ilim_nominal_trip = short_ckt || il >= 8'hC8;
  assign ilim_fold_trip = short_ckt || il >= 8'h42;
  assign ineg_limit = pd >= 8'h10;
endmodule // bcp_plant
`default_nettype wire

// file: verif/bcp_ctrl_tb_top.sv
// Bench for the switch control block with the far-side model.
// Assumes a 200 MHz clock and shortened long counts.
`timescale 1ns/10ps
`default_nettype none
module bcp_ctrl_tb_top;
  localparam [19:0] DISCH_CYC = 20'h32;
  localparam [15:0] MIN_OFF_CYC = 16'h28;
  localparam [15:0] MAX_ON_CYC = 16'h64;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic ea_at_bottom = 1'b0;
  logic feedback_below_fold = 1'b0;
  logic ramp_done = 1'b0;
  logic temp_hot = 1'b0;
  logic temp_release = 1'b1;
  logic enable_on = 1'b1;
  logic supply_ok = 1'b1;
  logic short_ckt = 1'b0;
  logic [7:0] pwm_len = 8'h28;
  logic [19:0] len;
  wire osc_period, pwm_end, ilim_nominal_trip, ilim_fold_trip;
  wire iskip_reached, ineg_limit, high_side_switch, low_side_pulldown;
  wire ramp_discharge, soft_start_active, thermal_shutdown, standby;
  wire [2:0] skip_count;
  int error_cnt = 0;
  int checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  bcp_ctrl #(.BOOT_CYC(20'hC8), .DISCH_CYC(DISCH_CYC),
    .MIN_OFF_CYC(MIN_OFF_CYC), .MAX_ON_CYC(MAX_ON_CYC)) dut_u (.*);
  bcp_plant plant_u (.*);
  task chk(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task ticks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Measures the next whole pulse, never a partial one
  task pulse;
    len = 20'h0;
    for (int i = 0; i < 400 && high_side_switch; i++) @(negedge clk_sys);
    for (int i = 0; i < 4000 && !high_side_switch; i++) @(negedge clk_sys);
    while (high_side_switch && len < 20'h400) begin
      len++;
      @(negedge clk_sys);
    end
  endtask
  task t_start;
    for (int i = 0; i < 20 && !ramp_discharge; i++) @(negedge clk_sys);
    len = 20'h0;
    while (ramp_discharge && len < 20'h400) begin
      len++;
      @(negedge clk_sys);
    end
    chk(len, DISCH_CYC);
    chk(soft_start_active, 1'b1);
    @(posedge clk_sys);
    feedback_below_fold <= 1'b1;
    pwm_len <= 8'h5A;
    pulse;
    chk(len > 20'h50, 1'b1);
    @(posedge clk_sys);
    ramp_done <= 1'b1;
    ticks(8);
    chk(soft_start_active, 1'b0);
    pulse;
    chk(len < 20'h50, 1'b1);
    @(posedge clk_sys);
    feedback_below_fold <= 1'b0;
    $display("start done");
  endtask
  task t_light;
    @(posedge clk_sys);
    ea_at_bottom <= 1'b1;
    ticks(120);
    len = 20'h0;
    repeat (300) begin
      @(negedge clk_sys);
      len = len | {19'h0, high_side_switch};
    end
    chk(len, 20'h0);
    chk(low_side_pulldown, 1'b1);
    @(posedge clk_sys);
    ea_at_bottom <= 1'b0;
    pwm_len <= 8'hFF;
    pulse;
    chk(len < 20'h28, 1'b1);
    $display("light done");
  endtask
  task t_maxon;
    pulse;
    chk(len, {4'h0, MAX_ON_CYC});
    ticks(1);
    len = 20'h0;
    while (low_side_pulldown && len < 20'h400) begin
      len++;
      @(negedge clk_sys);
    end
    chk(len > 20'h0 && len < 20'h20, 1'b1);
    $display("max on done");
  endtask
  task t_ocp;
    @(posedge clk_sys);
    pwm_len <= 8'h28;
    short_ckt <= 1'b1;
    pulse;
    chk(len, 20'h18);
    for (int i = 0; i < 20000 && skip_count !== 3'h7; i++) ticks(1);
    chk(skip_count, 3'h7);
    @(posedge clk_sys);
    short_ckt <= 1'b0;
    for (int i = 0; i < 20000 && skip_count !== 3'h0; i++) ticks(1);
    chk(skip_count, 3'h0);
    // Folded trip below skip current must not end the pulse at blank end
    @(posedge clk_sys);
    feedback_below_fold <= 1'b1;
    short_ckt <= 1'b1;
    pulse;
    chk(len, 20'h1F);
    chk(skip_count, 3'h0);
    @(posedge clk_sys);
    feedback_below_fold <= 1'b0;
    short_ckt <= 1'b0;
    $display("overcurrent done");
  endtask
  task t_idle;
    @(posedge clk_sys);
    enable_on <= 1'b0;
    ticks(8);
    chk(standby, 1'b1);
    @(posedge clk_sys);
    enable_on <= 1'b1;
    ticks(60);
    @(posedge clk_sys);
    temp_hot <= 1'b1;
    temp_release <= 1'b0;
    ticks(8);
    chk(thermal_shutdown, 1'b1);
    @(posedge clk_sys);
    temp_hot <= 1'b0;
    temp_release <= 1'b1;
    ticks(8);
    chk(ramp_discharge, 1'b1);
    $display("idle done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_start;
    t_light;
    t_maxon;
    t_ocp;
    t_idle;
    finish_test;
  end
  initial begin
    #400000;
    error_cnt++;
    finish_test;
  end
endmodule // bcp_ctrl_tb_top
bind bcp_ctrl bcp_ctrl_sva #(.DISCH_CYC(DISCH_CYC),
  .MIN_OFF_CYC(MIN_OFF_CYC), .MAX_ON_CYC(MAX_ON_CYC)) chk_u (.*);
`default_nettype wire
